// *** rtl/mvlr_regs.v ***
// Margin offset, OV/UV percent limit and options registers of a buck
// converter, with threshold generation and power-good hysteresis.
// Assumes a command decoder gives a one-cycle write or read strobe with a
// command code, and that reference and feedback arrive as unsigned codes.
//
// Notes on behaviour
// - margin-up selected adds the margin-up offset to the loop reference.
// - loop slave ignores margin and limit writes, NACKs, flags invalid command and raises alert.
// - margin values use exponent -9, one count per 1.953 mV step.
// - margin-up accepts 0 to 31 counts.
// - out-of-range margin clamps to nearer limit, alerts, sets summary and data bits.
// - reference is also bounded by max, min, command, scale and trim.
// - reference slews at rise, transition or fall rate by converter state.
// - margin-up is 16 bits, bits 4..0 writable, others read zero.
// - margin-up restores to 0009h or 000fh by its restore select bit.
// - margin-down selected adds the negative margin-down offset.
// - margin-down accepts -64 to -1 counts in two's complement.
// - margin-down writable bits 5..0 and sign, upper byte sign-extended ones.
// - margin-down restores to fff7h or fff1h by its restore select bit.
// - limit select is one byte, bits 1..0 writable and stored, reset zero.
// - select code picks UV fault and warning percentages 83/88,88/90,72/78,58/64.
// - OV warning/fault are 112/117 percent, code 01 gives 110/112.
// - power-good drops when feedback crosses OV or UV warning level.
// - power-good returns below 105 percent after OV, above 95 after UV.
// - options 16 bits, bit 15 reserved, bits 7 and 2 reset to one.
// - store-all-defaults copies options into nonvolatile storage.
// - options bit 0 disables negative current limit on low-side switch.
// - margin bits have no backup, restore only via options select bits.
// - reference is scaled command plus trim plus gated margins, times step.

`timescale 1ns/10ps
`default_nettype none
`include "mvlr_map.vh"

module mvlr_regs #(
	parameter REF_W = 12
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              nrst_i,
	// Command access
	input  wire              wr_i,
	input  wire              rd_i,
	input  wire [7:0]        cmd_i,
	input  wire [15:0]       wdata_i,
	input  wire              loop_slave_i,
	input  wire              store_all_i,
	input  wire              restore_i,
	input  wire [15:0]       nv_options_i,
	input  wire [7:0]        nv_pct_i,
	// Reference inputs
	input  wire [1:0]        operation_margin_i,
	input  wire [REF_W-1:0]  scaled_command_i,
	input  wire [15:0]       trim_i,
	input  wire [REF_W-1:0]  ref_max_i,
	input  wire [REF_W-1:0]  ref_min_i,
	input  wire [1:0]        conv_state_i,
	input  wire [REF_W-1:0]  feedback_input_i,
	// Register read back and bus status
	output reg  [15:0]       rdata_o,
	output reg               nack_o,
	output reg               invalid_command_fault_o,
	output reg               invalid_data_o,
	output reg               comm_memory_summary_bit_o,
	output reg               smbalert_o,
	// Stored copies
	output reg               nv_write_o,
	output reg  [15:0]       nv_options_o,
	output reg  [7:0]        nv_pct_o,
	// Derived controls
	output reg  [REF_W-1:0]  loop_reference_o,
	output reg  [1:0]        slew_select_o,
	output reg  [REF_W-1:0]  ov_warn_o,
	output reg  [REF_W-1:0]  ov_fault_o,
	output reg  [REF_W-1:0]  uv_warn_o,
	output reg  [REF_W-1:0]  uv_fault_o,
	output reg               power_good_o,
	output reg               negative_limit_disable_o,
	output reg               monitor_converter_enable_o,
	output reg               auto_alert_response_mask_o
);

	// Converter states for slew choice
	localparam ST_SOFT_START = 2'b00;
	localparam ST_STEADY     = 2'b01;
	localparam ST_OFF_DELAY  = 2'b10;
	localparam ST_SOFT_STOP  = 2'b11;
	// Slew rate selections
	localparam SLEW_RISE     = 2'b00;
	localparam SLEW_TRANS    = 2'b01;
	localparam SLEW_FALL     = 2'b10;

	reg  [4:0]  mup_q;
	reg  [6:0]  mdn_q;
	reg  [1:0]  pct_q;
	reg  [15:0] opt_q;

	// Register hit decode; slaves may not touch the margin and limit set
	wire hit_mup = (cmd_i == `MVLR_CMD_MARGIN_UP);
	wire hit_mdn = (cmd_i == `MVLR_CMD_MARGIN_DOWN);
	wire hit_pct = (cmd_i == `MVLR_CMD_LIMIT_PCT);
	wire hit_opt = (cmd_i == `MVLR_CMD_OPTIONS);
	wire locked  = loop_slave_i & (hit_mup | hit_mdn | hit_pct);
	wire acc     = wr_i | rd_i;
	wire wr_ok   = wr_i & ~locked;

	// Range checks on written margin values
	wire signed [15:0] wval   = wdata_i;
	wire mup_hi  = (wval > $signed(`MVLR_MUP_MAX));
	wire mup_lo  = wval[15];
	wire mdn_hi  = ~wval[15];
	wire mdn_lo  = (wval < $signed(`MVLR_MDN_MIN));
	wire bad_mup = wr_ok & hit_mup & (mup_hi | mup_lo);
	wire bad_mdn = wr_ok & hit_mdn & (mdn_hi | mdn_lo);

	// Restore targets chosen from options select bits; no own backup
	wire [15:0] mup_rst = opt_q[`MVLR_OPT_RSMHI_BIT] ? `MVLR_MUP_RESTORE_1
		: `MVLR_MUP_RESTORE_0;
	wire [15:0] mdn_rst = opt_q[`MVLR_OPT_RSMLO_BIT] ? `MVLR_MDN_RESTORE_1
		: `MVLR_MDN_RESTORE_0;

	// Register storage; read-only bits are simply never written
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mup_q <= `MVLR_MUP_RESET_Q;
			mdn_q <= `MVLR_MDN_RESET_Q;
			pct_q <= `MVLR_PCT_RESET_Q;
			opt_q <= `MVLR_OPT_RESET;
		end else if (restore_i) begin
			// A reload beats a same-cycle write so it is never half applied
			mup_q <= mup_rst[4:0];
			mdn_q <= {mdn_rst[15], mdn_rst[5:0]};
			pct_q <= nv_pct_i[1:0];
			opt_q <= nv_options_i & `MVLR_OPT_WR_MASK;
		end else if (wr_ok) begin
			if (hit_mup) begin
				// Clamp to the nearer limit
				if (mup_hi)
					mup_q <= 5'h1f;
				else if (mup_lo)
					mup_q <= 5'h00;
				else
					mup_q <= wdata_i[4:0];
			end
			if (hit_mdn) begin
				// Keep the sign set, clamp range
				if (mdn_hi)
					mdn_q <= 7'h7f;
				else if (mdn_lo)
					mdn_q <= 7'h40;
				else
					mdn_q <= {1'b1, wdata_i[5:0]};
			end
			if (hit_pct)
				pct_q <= wdata_i[1:0];
			if (hit_opt)
				opt_q <= wdata_i & `MVLR_OPT_WR_MASK;
		end
	end

	// Read mux and refusal pulse; a locked read answers zero so that no
	// margin or limit value leaks out of a loop-slave device
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 16'h0000;
			nack_o  <= 1'b0;
		end else begin
			nack_o <= acc & locked;
			if (rd_i & ~locked) begin
				case (cmd_i)
				`MVLR_CMD_MARGIN_UP: rdata_o <= {11'h000, mup_q};
				`MVLR_CMD_MARGIN_DOWN: rdata_o <= {{9{mdn_q[6]}}, mdn_q};
				`MVLR_CMD_LIMIT_PCT: rdata_o <= {14'h0000, pct_q};
				`MVLR_CMD_OPTIONS: rdata_o <= opt_q;
				default: rdata_o <= 16'h0000;
				endcase
			end else if (rd_i) begin
				rdata_o <= 16'h0000;
			end
		end
	end

	// Status flags are sticky until reset; with no clear port the host
	// sees every refusal or clamp since power-up
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			invalid_command_fault_o   <= 1'b0;
			invalid_data_o            <= 1'b0;
			comm_memory_summary_bit_o <= 1'b0;
			smbalert_o                <= 1'b0;
		end else begin
			if (acc & locked)
				invalid_command_fault_o <= 1'b1;
			if (bad_mup | bad_mdn)
				invalid_data_o <= 1'b1;
			if ((acc & locked) | bad_mup | bad_mdn) begin
				comm_memory_summary_bit_o <= 1'b1;
				smbalert_o                <= 1'b1;
			end
		end
	end

	// Reference sum in steps, gated margins, then bounded
	// Trim is cut to the sum width, which holds for REF_W up to 13 only
	wire signed [REF_W+2:0] ref_sum = $signed({3'b000, scaled_command_i})
		+ $signed(trim_i[REF_W+2:0])
		+ (operation_margin_i[1] ? $signed({{(REF_W-2){1'b0}}, mup_q})
			: $signed({(REF_W+3){1'b0}}))
		+ (operation_margin_i[0] ? $signed({{(REF_W-4){mdn_q[6]}}, mdn_q})
			: $signed({(REF_W+3){1'b0}}));
	wire signed [REF_W+2:0] s_max = $signed({3'b000, ref_max_i});
	wire signed [REF_W+2:0] s_min = $signed({3'b000, ref_min_i});
	wire [REF_W-1:0] ref_clip = (ref_sum > s_max) ? ref_max_i
		: (ref_sum < s_min) ? ref_min_i : ref_sum[REF_W-1:0];

	// Percent of a reference value; division truncates, and a level above
	// full scale saturates, since a wrapped OV level would trip at once
	function [REF_W-1:0] pct_of;
		input [REF_W-1:0] r;
		input [7:0]       p;
		reg   [REF_W+7:0] prod;
		reg   [REF_W+7:0] quot;
		begin
			prod = r * p;
			quot = prod / 8'd100;
			if (quot > {{8{1'b0}}, {REF_W{1'b1}}})
				pct_of = {REF_W{1'b1}};
			else
				pct_of = quot[REF_W-1:0];
		end
	endfunction

	// UV and OV percentage tables by select code
	reg [7:0] uvf_p;
	reg [7:0] uvw_p;
	reg [7:0] ovw_p;
	reg [7:0] ovf_p;
	always @* begin
		ovw_p = 8'd112;
		ovf_p = 8'd117;
		case (pct_q)
		2'b00: begin
			uvf_p = 8'd83;
			uvw_p = 8'd88;
		end
		// Code 01 is the narrow window, so the OV levels move in as well
		2'b01: begin
			uvf_p = 8'd88;
			uvw_p = 8'd90;
			ovw_p = 8'd110;
			ovf_p = 8'd112;
		end
		2'b10: begin
			uvf_p = 8'd72;
			uvw_p = 8'd78;
		end
		default: begin
			uvf_p = 8'd58;
			uvw_p = 8'd64;
		end
		endcase
	end

	// Power-good trip and release against the current reference
	wire [REF_W-1:0] ovw_lvl = pct_of(loop_reference_o, ovw_p);
	wire [REF_W-1:0] uvw_lvl = pct_of(loop_reference_o, uvw_p);
	wire [REF_W-1:0] ov_rel  = pct_of(loop_reference_o, `MVLR_PG_OV_RELEASE);
	wire [REF_W-1:0] uv_rel  = pct_of(loop_reference_o, `MVLR_PG_UV_RELEASE);
	wire [REF_W-1:0] ovf_lvl = pct_of(loop_reference_o, ovf_p);
	wire [REF_W-1:0] uvf_lvl = pct_of(loop_reference_o, uvf_p);
	// Live crossings, used both to trip and to drop power-good at once
	wire             ov_cross = (feedback_input_i > ovw_lvl);
	wire             uv_cross = (feedback_input_i < uvw_lvl);
	reg ov_trip_q;
	reg uv_trip_q;

	// Outputs derived from registers, all flopped
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loop_reference_o           <= {REF_W{1'b0}};
			slew_select_o              <= SLEW_RISE;
			ov_warn_o                  <= {REF_W{1'b0}};
			ov_fault_o                 <= {REF_W{1'b0}};
			uv_warn_o                  <= {REF_W{1'b0}};
			uv_fault_o                 <= {REF_W{1'b0}};
			ov_trip_q                  <= 1'b0;
			uv_trip_q                  <= 1'b0;
			power_good_o               <= 1'b0;
		end else begin
			loop_reference_o <= ref_clip;
			// Turn-off delay keeps the steady transition rate
			case (conv_state_i)
			ST_SOFT_START: slew_select_o <= SLEW_RISE;
			ST_STEADY:     slew_select_o <= SLEW_TRANS;
			ST_OFF_DELAY:  slew_select_o <= SLEW_TRANS;
			ST_SOFT_STOP:  slew_select_o <= SLEW_FALL;
			default:       slew_select_o <= SLEW_TRANS;
			endcase
			ov_warn_o  <= ovw_lvl;
			ov_fault_o <= ovf_lvl;
			uv_warn_o  <= uvw_lvl;
			uv_fault_o <= uvf_lvl;
			// Trip on crossing, hold until the hysteresis point
			if (ov_cross)
				ov_trip_q <= 1'b1;
			else if (feedback_input_i < ov_rel)
				ov_trip_q <= 1'b0;
			if (uv_cross)
				uv_trip_q <= 1'b1;
			else if (feedback_input_i > uv_rel)
				uv_trip_q <= 1'b0;
			// The trip flags lag a cycle, so the live crossing also gates
			// power-good and a one-cycle spike still drops it
			power_good_o <= ~(ov_trip_q | uv_trip_q) & ~ov_cross & ~uv_cross;
		end
	end

	// Option bit copies and the store snapshot; the copies follow the
	// register every cycle, so a write takes effect one cycle later
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			negative_limit_disable_o   <= 1'b0;
			monitor_converter_enable_o <= 1'b1;
			auto_alert_response_mask_o <= 1'b1;
			nv_write_o                 <= 1'b0;
			nv_options_o               <= `MVLR_OPT_RESET;
			nv_pct_o                   <= `MVLR_PCT_RESET;
		end else begin
			negative_limit_disable_o   <= opt_q[`MVLR_OPT_NEGLIM_BIT];
			monitor_converter_enable_o <= opt_q[`MVLR_OPT_MONADC_BIT];
			auto_alert_response_mask_o <= opt_q[`MVLR_OPT_AUTOARA_BIT];
			// Snapshot for nonvolatile store
			nv_write_o <= store_all_i;
			if (store_all_i) begin
				nv_options_o <= opt_q;
				nv_pct_o     <= {6'h00, pct_q};
			end
		end
	end

endmodule // mvlr_regs

`default_nettype wire

// *** shared/mvlr_map.vh ***
// Register map constants for the margin and voltage limit register bank.
// Assumes byte-wide command codes on the management bus side.
`ifndef MVLR_MAP_VH
`define MVLR_MAP_VH

// Command codes
`define MVLR_CMD_MARGIN_UP        8'hd5
`define MVLR_CMD_MARGIN_DOWN      8'hd6
`define MVLR_CMD_LIMIT_PCT        8'hd7
`define MVLR_CMD_OPTIONS          8'he5

// Margin-up restore values and range
`define MVLR_MUP_RESTORE_0        16'h0009
`define MVLR_MUP_RESTORE_1        16'h000f
`define MVLR_MUP_MAX              16'h001f

// Margin-down restore values and range
`define MVLR_MDN_RESTORE_0        16'hfff7
`define MVLR_MDN_RESTORE_1        16'hfff1
`define MVLR_MDN_MIN              16'hffc0

// Options layout and reset value
`define MVLR_OPT_RESET            16'h0084
`define MVLR_OPT_WR_MASK          16'h7fff
`define MVLR_OPT_NEGLIM_BIT       0
`define MVLR_OPT_MONADC_BIT       2
`define MVLR_OPT_AUTOARA_BIT      7
`define MVLR_OPT_RSMLO_BIT        13
`define MVLR_OPT_RSMHI_BIT        14

// Limit select register
`define MVLR_PCT_RESET            8'h00
`define MVLR_PCT_WR_MASK          8'h03

// Reset values at the stored widths of the margin and limit registers
`define MVLR_MUP_RESET_Q          5'h09
`define MVLR_MDN_RESET_Q          7'h77
`define MVLR_PCT_RESET_Q          2'h0

// Hysteresis release points in percent
`define MVLR_PG_OV_RELEASE        8'd105
`define MVLR_PG_UV_RELEASE        8'd95

`endif

// *** sim/mvlr_regs_monitor.sv ***
// Checker for the margin and limit register bank.
// Assumes it is bound to mvlr_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mvlr_regs_monitor (
	// Clock, reset and requests
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  cmd_i,
	input wire logic [15:0] wdata_i,
	input wire logic        loop_slave_i,
	input wire logic        store_all_i,
	input wire logic [1:0]  conv_state_i,
	// Answers
	input wire logic [15:0] rdata_o,
	input wire logic        nack_o,
	input wire logic        invalid_command_fault_o,
	input wire logic        invalid_data_o,
	input wire logic        smbalert_o,
	input wire logic        nv_write_o,
	input wire logic [1:0]  slew_select_o
);
	// One domain, so one clock and reset serve every property
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic rdm;
	// Reads from a master device only; a slave reads margin and limit back as zero
	assign rdm = rd_i && !loop_slave_i;
	AST_SLAVE_NACK: assert property ((wr_i || rd_i) && loop_slave_i && cmd_i == 8'hd5
		|=> nack_o && invalid_command_fault_o && smbalert_o) else $error("locked access kept");
	AST_MUP_READ: assert property (rdm && cmd_i == 8'hd5 |=> rdata_o <= 16'h001f)
		else $error("margin-up readback out of range");
	AST_MDN_READ: assert property (rdm && cmd_i == 8'hd6 |=> rdata_o[15:6] == 10'h3ff)
		else $error("margin-down upper bits not ones");
	AST_PCT_READ: assert property (rdm && cmd_i == 8'hd7 |=> rdata_o[15:2] == 14'h0)
		else $error("limit select upper bits set");
	AST_OPT_READ: assert property (rdm && cmd_i == 8'he5 |=> !rdata_o[15])
		else $error("reserved option bit set");
	AST_CLAMP: assert property (wr_i && !loop_slave_i && cmd_i == 8'hd5 && wdata_i > 16'h1f
		|=> invalid_data_o && smbalert_o) else $error("clamp not flagged");
	AST_STORE: assert property (store_all_i ##1 !store_all_i |-> nv_write_o ##1 !nv_write_o)
		else $error("store pulse wrong");
	AST_SLEW: assert property (conv_state_i == 2'd3 |=> slew_select_o == 2'd2)
		else $error("soft-stop slew not fall rate");
endmodule // mvlr_regs_monitor
bind mvlr_regs mvlr_regs_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i),
	.rd_i(rd_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .loop_slave_i(loop_slave_i),
	.store_all_i(store_all_i), .conv_state_i(conv_state_i), .rdata_o(rdata_o), .nack_o(nack_o),
	.invalid_command_fault_o(invalid_command_fault_o), .invalid_data_o(invalid_data_o),
	.smbalert_o(smbalert_o), .nv_write_o(nv_write_o), .slew_select_o(slew_select_o));
`default_nettype wire

// *** sim/mvlr_host.sv ***
// Host model driving the command port, one access per call.
// Assumes the bench calls xfer; requests change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module mvlr_host (
	// Bus side
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	output var  logic        wr_o,
	output var  logic        rd_o,
	output var  logic [7:0]  cmd_o,
	output var  logic [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// One-cycle strobe; released lines show the inverse so stale data is never reused
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clk_i);
		wr_o = w;
		rd_o = ~w;
		cmd_o = c;
		wdata_o = d;
		@(negedge clk_i);
		q = rdata_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = ~c;
		wdata_o = ~d;
	endtask
endmodule // mvlr_host
`default_nettype wire

// *** sim/tb.sv ***
// Bench for the margin and limit register bank.
// Assumes REF_W of 12 and a reference of 1000 codes for the percent levels.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0, nrst = 1'b0, slave = 1'b0, store = 1'b0, rest = 1'b0;
	logic        wr, rd, nvw, pg, nack, invalid_command_fault, ivd, comm_memory_summary_bit, alrt, nld, mce, aam;
	logic [1:0]  marg = 2'b00, state = 2'b01, slew;
	logic [7:0]  cmd, nvp;
	logic [15:0] wd, rdat, q, nvo;
	logic [15:0] trim = 16'h0000;
	logic [11:0] rmin = 12'h000;
	logic [11:0] cmdv = 12'd1000, rmax = 12'hfff, fb = 12'd1000, lref, ovw, ovf, uvw, uvf;
	logic [7:0]  cs[8] = '{8'hd5, 8'hd6, 8'hd7, 8'he5, 8'hd5, 8'hd6, 8'hd7, 8'he5};
	logic [15:0] ev[8] = '{16'h0009, 16'hfff7, 16'h0000, 16'h0084, 16'h000f, 16'hfff1, 16'h0002, 16'h6084};
	logic [7:0]  wc[8] = '{8'hd5, 8'hd6, 8'hd5, 8'hd5, 8'hd6, 8'hd6, 8'hd7, 8'he5};
	logic [15:0] wv[8] = '{16'h0012, 16'hffc5, 16'h0040, 16'hffff, 16'h0000, 16'hff00, 16'h00ff, 16'hffff};
	logic [15:0] we[8] = '{16'h0012, 16'hffc5, 16'h001f, 16'h0000, 16'hffff, 16'hffc0, 16'h0003, 16'h7fff};
	int          uf[4] = '{83, 88, 72, 58}, uw[4] = '{88, 90, 78, 64};
	int          ow[4] = '{112, 110, 112, 112}, of[4] = '{117, 112, 117, 117};
	int          mx[4] = '{4095, 4095, 1010, 4095}, re[4] = '{1018, 941, 1010, 1000};
	int          fv[7] = '{1000, 1130, 1060, 1040, 870, 940, 960}, pv[7] = '{1, 0, 0, 1, 0, 0, 1};
	int          n_errors = 0, n_compared = 0;
	// Free-running 250 MHz clock
	initial forever #2 clk = ~clk;
	// Design; the stored copies are held at fixed values
	mvlr_regs #(.REF_W(12)) dut (.clk_i(clk), .nrst_i(nrst), .wr_i(wr), .rd_i(rd), .cmd_i(cmd),
		.wdata_i(wd), .loop_slave_i(slave), .store_all_i(store), .restore_i(rest),
		.nv_options_i(16'he084), .nv_pct_i(8'h02), .operation_margin_i(marg),
		.scaled_command_i(cmdv), .trim_i(trim), .ref_max_i(rmax), .ref_min_i(rmin),
		.conv_state_i(state), .feedback_input_i(fb), .rdata_o(rdat), .nack_o(nack),
		.invalid_command_fault_o(invalid_command_fault), .invalid_data_o(ivd), .comm_memory_summary_bit_o(comm_memory_summary_bit),
		.smbalert_o(alrt), .nv_write_o(nvw), .nv_options_o(nvo), .nv_pct_o(nvp),
		.loop_reference_o(lref), .slew_select_o(slew), .ov_warn_o(ovw), .ov_fault_o(ovf),
		.uv_warn_o(uvw), .uv_fault_o(uvf), .power_good_o(pg), .negative_limit_disable_o(nld),
		.monitor_converter_enable_o(mce), .auto_alert_response_mask_o(aam));
	mvlr_host host (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wd));
	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog so a hang still ends in the report
	initial begin
		#40000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		for (int k = 0; k < 4; k++) begin
			host.xfer(1'b0, cs[k], 16'h0000, q);
			check("reset value", q, ev[k]);
		end
		check("reset option outs", 16'({nld, mce, aam}), 16'h0003);
		// Legal, clamped and masked writes, each read back
		for (int k = 0; k < 8; k++) begin
			if (k == 2) check("invalid_data", 16'(ivd), 16'h0000);
			host.xfer(1'b1, wc[k], wv[k], q);
			host.xfer(1'b0, wc[k], 16'h0000, q);
			check("readback", q, we[k]);
		end
		check("data flags", 16'({ivd, comm_memory_summary_bit, alrt}), 16'h0007);
		check("option outs", 16'({nld, mce, aam}), 16'h0007);
		// Restore takes margins from the select bits, the rest from the stored copy
		host.xfer(1'b1, 8'he5, 16'h6000, q);
		rest = 1'b1;
		@(negedge clk);
		rest = 1'b0;
		for (int k = 4; k < 8; k++) begin
			host.xfer(1'b0, cs[k], 16'h0000, q);
			check("restored", q, ev[k]);
		end
		check("restored option outs", 16'({nld, mce, aam}), 16'h0003);
		store = 1'b1;
		@(negedge clk);
		store = 1'b0;
		check("nv_write", 16'(nvw), 16'h0001);
		check("nv_options", nvo, 16'h6084);
		check("nv_pct", 16'(nvp), 16'h0002);
		// Margin gating and the upper bound on the reference
		host.xfer(1'b1, 8'hd5, 16'h0012, q);
		host.xfer(1'b1, 8'hd6, 16'hffc5, q);
		for (int k = 0; k < 4; k++) begin
			marg = (k == 1) ? 2'b01 : (k == 3) ? 2'b00 : 2'b10;
			rmax = 12'(mx[k]);
			repeat (2) @(negedge clk);
			check("loop_reference", 16'(lref), 16'(re[k]));
		end
		// Trim and the lower bound also steer the reference
		trim = 16'hfff6;
		repeat (2) @(negedge clk);
		check("trim_reference", 16'(lref), 16'd990);
		rmin = 12'd995;
		repeat (2) @(negedge clk);
		check("min_reference", 16'(lref), 16'd995);
		trim = 16'h0000;
		rmin = 12'h000;
		for (int k = 3; k >= 0; k--) begin
			host.xfer(1'b1, 8'hd7, 16'(k), q);
			repeat (3) @(negedge clk);
			check("uv_fault", 16'(uvf), 16'(uf[k] * 10));
			check("uv_warn", 16'(uvw), 16'(uw[k] * 10));
			check("ov_warn", 16'(ovw), 16'(ow[k] * 10));
			check("ov_fault", 16'(ovf), 16'(of[k] * 10));
		end
		// Trip and hysteresis band on both sides
		for (int k = 0; k < 7; k++) begin
			fb = 12'(fv[k]);
			repeat (4) @(negedge clk);
			check("power_good", 16'(pg), 16'(pv[k]));
		end
		for (int k = 0; k < 4; k++) begin
			state = 2'(k);
			repeat (2) @(negedge clk);
			check("slew_select", 16'(slew), 16'((k + 1) / 2));
		end
		slave = 1'b1;
		host.xfer(1'b1, 8'hd5, 16'h0003, q);
		check("refusal", 16'({nack, invalid_command_fault, alrt}), 16'h0007);
		host.xfer(1'b0, 8'hd6, 16'h0000, q);
		check("locked read", q, 16'h0000);
		slave = 1'b0;
		host.xfer(1'b0, 8'hd5, 16'h0000, q);
		check("ignored write", q, 16'h0012);
		finish_test();
	end
endmodule // tb
`default_nettype wire
